// *** shared/exec_pkg.sv ***
// package: constants, opcodes and carriers of the set-to-xor execute block
package exec_pkg;

	// ------------------------------------------------------------
	// widths and sizes
	// ------------------------------------------------------------
	localparam int DATA_W     = 8;
	localparam int NIBBLE_W   = 4;
	localparam int FILE_DEPTH = 16;
	localparam int FILE_IDX_W = 4;
	localparam int BIT_IDX_W  = 3;
	localparam int OP_W       = 5;
	localparam int ADDR_W     = 8;
	localparam int CYCLE_W    = 16;

	// ------------------------------------------------------------
	// apb register byte offsets
	// ------------------------------------------------------------
	localparam logic [ADDR_W-1:0] OFS_INSN   = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_WORK   = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_FLAGS  = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_STATE  = 8'h0c;
	localparam logic [ADDR_W-1:0] OFS_CYCLES = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_FILE   = 8'h40;
	localparam logic [ADDR_W-1:0] FILE_MASK  = 8'hc0;

	// ------------------------------------------------------------
	// instruction word fields
	// ------------------------------------------------------------
	localparam int INSN_OP_LSB  = 0;
	localparam int INSN_BIT_LSB = 8;
	localparam int INSN_IDX_LSB = 12;
	localparam int INSN_IMM_LSB = 16;

	// flags register bit positions
	localparam int FLAG_BORROW = 0;
	localparam int FLAG_HALF   = 1;
	localparam int FLAG_NIL    = 2;
	localparam int FLAG_SIGNED = 3;
	localparam int FLAG_WDT    = 4;
	localparam int FLAG_SLEEP  = 5;
	localparam int FLAG_W      = 6;

	// state register: write this bit to wake the core
	localparam int STATE_WAKE_BIT = 0;

	// reset values and port register index
	localparam logic [DATA_W-1:0]     WORK_RESET = 8'h00;
	localparam logic [DATA_W-1:0]     FILE_RESET = 8'h00;
	localparam logic [DATA_W-1:0]     ALL_ONES   = 8'hff;
	localparam logic [DATA_W-1:0]     ONE        = 8'h01;
	localparam logic [FILE_IDX_W-1:0] PORT_INDEX = 4'h0;

	// ------------------------------------------------------------
	// opcodes
	// ------------------------------------------------------------
	typedef enum logic [OP_W-1:0] {
		op_nop                           = 5'h00,
		op_set_all                       = 5'h01,
		op_bit_force_high                = 5'h02,
		op_stop                          = 5'h03,
		op_subtract_from_immediate       = 5'h04,
		op_subtract_into_work            = 5'h05,
		op_subtract_into_reg             = 5'h06,
		op_subtract_with_borrow_to_work  = 5'h07,
		op_subtract_with_borrow_to_reg   = 5'h08,
		op_nibble_exchange_to_work       = 5'h09,
		op_nibble_exchange_to_reg        = 5'h0a,
		op_skip_if_bit_clear             = 5'h0b,
		op_skip_if_bit_set               = 5'h0c,
		op_load_work_skip_if_zero        = 5'h0d,
		op_retest_reg_skip_if_zero       = 5'h0e,
		op_increment_to_work_skip_if_zero    = 5'h0f,
		op_increment_in_place_skip_if_zero   = 5'h10,
		op_decrement_to_work_skip_if_zero    = 5'h11,
		op_decrement_in_place_skip_if_zero   = 5'h12,
		op_reg_zero_probe                = 5'h13,
		op_exclusive_or_immediate        = 5'h14,
		op_exclusive_or_into_work        = 5'h15,
		op_exclusive_or_into_reg         = 5'h16
	} opcode_t;

	// core state, gray along run -> skip -> sleep
	typedef enum logic [1:0] {
		st_run   = 2'b00,
		st_skip  = 2'b01,
		st_sleep = 2'b11
	} core_state_t;

	// status flags
	typedef struct packed {
		logic sleep_entered_flag;
		logic watchdog_expired_flag;
		logic signed_range_flag;
		logic result_nil_flag;
		logic half_borrow_flag;
		logic borrow_bit;
	} flags_t;

	// decoded instruction word
	typedef struct packed {
		logic [DATA_W-1:0]     imm;
		logic [FILE_IDX_W-1:0] idx;
		logic [BIT_IDX_W-1:0]  bit_sel;
		logic [OP_W-1:0]       op;
	} insn_t;

	// subtractor results
	typedef struct packed {
		logic [DATA_W-1:0] diff;
		logic              borrow;
		logic              half_borrow;
		logic              overflow;
	} sub_out_t;

endpackage

// *** src/exec_core.sv ***
// file: execute stage for set-all through exclusive-or, with apb access
// ------------------------------------------------------------
// Summary of operation
// - set-all writes ff into the register in one cycle, flags kept
// - bit_force_high sets one chosen bit in one cycle, others and flags kept
// - stop takes one cycle, updates watchdog and sleep flags, halts core and clock
// - while asleep every port pin holds its value from before sleep
// - subtract_from_immediate puts immediate minus work into work, four flags updated
// - register minus work into work or register, four arithmetic flags updated
// - register minus work minus borrow into work or register, four flags updated
// - nibble exchange of register into work or register, one cycle, no flags
// - skip_if_bit_clear skips next instruction when chosen bit is zero
// - skip_if_bit_set skips when bit is one, one or two cycles, no flags
// - copy register to work or itself, skip if zero, no flags
// - increment register to work or register, skip when result zero, no flags
// - decrement register to work or register, skip when result zero
// - reg_zero_probe rewrites register with itself, only nil flag updated
// - exclusive_or_immediate xors immediate with work into work, nil flag updated
// - xor register with work into work or register, nil flag only
// ------------------------------------------------------------
//
// The register offsets and the APB register port were decided locally.
`timescale 1ns/100ps
`default_nettype none

module exec_core
	import exec_pkg::*;
#(
	parameter int DEPTH = FILE_DEPTH
) (
	input  wire logic              clk_sys_in,
	input  wire logic              resetn_in,
	input  wire logic              psel_in,
	input  wire logic              penable_in,
	input  wire logic              pwrite_in,
	input  wire logic [ADDR_W-1:0] paddr_in,
	input  wire logic [31:0]       pwdata_in,
	output logic      [31:0]       prdata_out,
	output logic                   pready_out,
	output logic                   pslverr_out,
	input  wire logic              wake_in,
	output logic      [DATA_W-1:0] io_port_out,
	output logic                   sleep_out,
	output logic                   clock_run_out
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	core_state_t         state,      next_state;
	logic [DATA_W-1:0]   work,       next_work;
	flags_t              flags,      next_flags;
	logic [DATA_W-1:0]   file_mem   [DEPTH];
	logic [DATA_W-1:0]   next_file  [DEPTH];
	insn_t               last_insn,  next_last_insn;
	logic [CYCLE_W-1:0]  cycles,     next_cycles;
	logic [31:0]         rd_data,    next_rd_data;

	// ------------------------------------------------------------
	// decode and operands
	// ------------------------------------------------------------
	logic                setup;
	logic                access;
	logic                wr;
	logic                addr_file;
	logic                addr_known;
	logic                asleep;
	insn_t               insn;
	logic [DATA_W-1:0]   operand;
	logic [DATA_W-1:0]   sub_a;
	logic                sub_bin;
	sub_out_t            sub_res;
	logic [DATA_W-1:0]   inc_val;
	logic [DATA_W-1:0]   dec_val;
	logic [DATA_W-1:0]   bit_mask;
	logic                op_legal;
	logic                refuse;

	assign setup      = psel_in && !penable_in;
	assign access     = psel_in && penable_in;
	assign wr         = access && pwrite_in;
	assign addr_file  = (paddr_in & FILE_MASK) == OFS_FILE;
	assign addr_known = addr_file || paddr_in == OFS_INSN || paddr_in == OFS_WORK
		|| paddr_in == OFS_FLAGS || paddr_in == OFS_STATE || paddr_in == OFS_CYCLES;
	assign asleep     = state == st_sleep;
	assign insn       = {pwdata_in[INSN_IMM_LSB +: DATA_W], pwdata_in[INSN_IDX_LSB +: FILE_IDX_W],
		pwdata_in[INSN_BIT_LSB +: BIT_IDX_W], pwdata_in[INSN_OP_LSB +: OP_W]};
	assign operand    = file_mem[insn.idx];
	assign inc_val    = operand + ONE;
	assign dec_val    = operand - ONE;
	assign bit_mask   = ONE << insn.bit_sel;

	always_comb begin
		unique case (opcode_t'(insn.op))
			op_nop, op_set_all, op_bit_force_high, op_stop, op_subtract_from_immediate,
			op_subtract_into_work, op_subtract_into_reg, op_subtract_with_borrow_to_work,
			op_subtract_with_borrow_to_reg, op_nibble_exchange_to_work,
			op_nibble_exchange_to_reg, op_skip_if_bit_clear, op_skip_if_bit_set,
			op_load_work_skip_if_zero, op_retest_reg_skip_if_zero,
			op_increment_to_work_skip_if_zero, op_increment_in_place_skip_if_zero,
			op_decrement_to_work_skip_if_zero, op_decrement_in_place_skip_if_zero,
			op_reg_zero_probe, op_exclusive_or_immediate, op_exclusive_or_into_work,
			op_exclusive_or_into_reg:
				op_legal = 1'b1;
			default:
				op_legal = 1'b0;
		endcase
	end

	// immediate form uses the immediate as minuend, others the register
	always_comb begin
		sub_a   = operand;
		sub_bin = 1'b0;
		if (insn.op == op_subtract_from_immediate) begin
			sub_a = insn.imm;
		end
		if (insn.op == op_subtract_with_borrow_to_work
			|| insn.op == op_subtract_with_borrow_to_reg) begin
			sub_bin = flags.borrow_bit;
		end
	end

	sub_unit #(
		.WIDTH (DATA_W),
		.HALF  (NIBBLE_W)
	) u_sub (
		.minuend_in      (sub_a),
		.subtrahend_in   (work),
		.borrow_in       (sub_bin),
		.diff_out        (sub_res.diff),
		.borrow_out      (sub_res.borrow),
		.half_borrow_out (sub_res.half_borrow),
		.overflow_out    (sub_res.overflow)
	);

	// ------------------------------------------------------------
	// apb answer
	// ------------------------------------------------------------
	// writes to any register but the state register are refused while asleep
	assign refuse = !addr_known
		|| (pwrite_in && asleep && paddr_in != OFS_STATE && paddr_in != OFS_CYCLES)
		|| (pwrite_in && paddr_in == OFS_INSN && !op_legal)
		|| (pwrite_in && paddr_in == OFS_CYCLES);

	assign pready_out    = 1'b1;
	assign pslverr_out   = access && refuse;
	assign prdata_out    = rd_data;
	assign io_port_out   = file_mem[PORT_INDEX];
	assign sleep_out     = asleep;
	assign clock_run_out = !asleep;

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		logic skip;
		logic nil_upd;
		logic arith_upd;
		logic [DATA_W-1:0] res;
		skip           = 1'b0;
		nil_upd        = 1'b0;
		arith_upd      = 1'b0;
		res            = '0;
		next_state     = state;
		next_work      = work;
		next_flags     = flags;
		next_file      = file_mem;
		next_last_insn = last_insn;
		next_cycles    = cycles;
		next_rd_data   = rd_data;

		// read data captured in the setup cycle
		if (setup && !pwrite_in) begin
			next_rd_data = '0;
			if (addr_file) begin
				next_rd_data[DATA_W-1:0] = file_mem[paddr_in[FILE_IDX_W+1:2]];
			end else if (paddr_in == OFS_INSN) begin
				next_rd_data[INSN_IMM_LSB +: DATA_W]     = last_insn.imm;
				next_rd_data[INSN_IDX_LSB +: FILE_IDX_W] = last_insn.idx;
				next_rd_data[INSN_BIT_LSB +: BIT_IDX_W]  = last_insn.bit_sel;
				next_rd_data[INSN_OP_LSB +: OP_W]        = last_insn.op;
			end else if (paddr_in == OFS_WORK) begin
				next_rd_data[DATA_W-1:0] = work;
			end else if (paddr_in == OFS_FLAGS) begin
				next_rd_data[FLAG_W-1:0] = flags;
			end else if (paddr_in == OFS_STATE) begin
				next_rd_data[1:0] = state;
			end else if (paddr_in == OFS_CYCLES) begin
				next_rd_data[CYCLE_W-1:0] = cycles;
			end
		end

		if (asleep && wake_in) begin
			next_state = st_run;
		end

		if (wr && !refuse) begin
			if (addr_file) begin
				next_file[paddr_in[FILE_IDX_W+1:2]] = pwdata_in[DATA_W-1:0];
			end else if (paddr_in == OFS_WORK) begin
				next_work = pwdata_in[DATA_W-1:0];
			end else if (paddr_in == OFS_FLAGS) begin
				next_flags = flags_t'(pwdata_in[FLAG_W-1:0]);
			end else if (paddr_in == OFS_STATE) begin
				if (asleep && pwdata_in[STATE_WAKE_BIT]) begin
					next_state = st_run;
				end
			end else if (paddr_in == OFS_INSN) begin
				next_last_insn = insn;
				next_cycles    = cycles + 16'h0001;
				if (state == st_skip) begin
					next_state = st_run;
				end else begin
					unique case (opcode_t'(insn.op))
						op_set_all: begin
							next_file[insn.idx] = ALL_ONES;
						end
						op_bit_force_high: begin
							next_file[insn.idx] = operand | bit_mask;
						end
						op_stop: begin
							next_flags.watchdog_expired_flag = 1'b0;
							next_flags.sleep_entered_flag    = 1'b1;
							next_state = st_sleep;
						end
						op_subtract_from_immediate, op_subtract_into_work,
						op_subtract_with_borrow_to_work: begin
							next_work = sub_res.diff;
							res       = sub_res.diff;
							arith_upd = 1'b1;
						end
						op_subtract_into_reg, op_subtract_with_borrow_to_reg: begin
							next_file[insn.idx] = sub_res.diff;
							res       = sub_res.diff;
							arith_upd = 1'b1;
						end
						op_nibble_exchange_to_work: begin
							next_work = {operand[NIBBLE_W-1:0],
								operand[DATA_W-1:NIBBLE_W]};
						end
						op_nibble_exchange_to_reg: begin
							next_file[insn.idx] = {operand[NIBBLE_W-1:0],
								operand[DATA_W-1:NIBBLE_W]};
						end
						op_skip_if_bit_clear: begin
							skip = !operand[insn.bit_sel];
						end
						op_skip_if_bit_set: begin
							skip = operand[insn.bit_sel];
						end
						op_load_work_skip_if_zero: begin
							next_work = operand;
							skip = operand == '0;
						end
						op_retest_reg_skip_if_zero: begin
							skip = operand == '0;
						end
						op_increment_to_work_skip_if_zero: begin
							next_work = inc_val;
							skip = inc_val == '0;
						end
						op_increment_in_place_skip_if_zero: begin
							next_file[insn.idx] = inc_val;
							skip = inc_val == '0;
						end
						op_decrement_to_work_skip_if_zero: begin
							next_work = dec_val;
							skip = dec_val == '0;
						end
						op_decrement_in_place_skip_if_zero: begin
							next_file[insn.idx] = dec_val;
							skip = dec_val == '0;
						end
						op_reg_zero_probe: begin
							res     = operand;
							nil_upd = 1'b1;
						end
						op_exclusive_or_immediate, op_exclusive_or_into_work: begin
							res = (insn.op == op_exclusive_or_immediate)
								? insn.imm ^ work : operand ^ work;
							next_work = res;
							nil_upd   = 1'b1;
						end
						op_exclusive_or_into_reg: begin
							res = operand ^ work;
							next_file[insn.idx] = res;
							nil_upd = 1'b1;
						end
						default: begin
						end
					endcase
					if (skip) begin
						next_state = st_skip;
					end
					if (arith_upd) begin
						next_flags.borrow_bit        = sub_res.borrow;
						next_flags.half_borrow_flag  = sub_res.half_borrow;
						next_flags.signed_range_flag = sub_res.overflow;
					end
					if (arith_upd || nil_upd) begin
						next_flags.result_nil_flag = res == '0;
					end
				end
			end
		end
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			state     <= st_run;
			work      <= WORK_RESET;
			flags     <= '0;
			file_mem  <= '{default: FILE_RESET};
			last_insn <= '0;
			cycles    <= '0;
			rd_data   <= '0;
		end else begin
			state     <= next_state;
			work      <= next_work;
			flags     <= next_flags;
			file_mem  <= next_file;
			last_insn <= next_last_insn;
			cycles    <= next_cycles;
			rd_data   <= next_rd_data;
		end
	end

endmodule // exec_core

`default_nettype wire

// *** src/sub_unit.sv ***
// file: borrow subtractor with half-borrow and signed overflow
`timescale 1ns/100ps
`default_nettype none

module sub_unit
	import exec_pkg::*;
#(
	parameter int WIDTH = DATA_W,
	parameter int HALF  = NIBBLE_W
) (
	input  wire logic [WIDTH-1:0] minuend_in,
	input  wire logic [WIDTH-1:0] subtrahend_in,
	input  wire logic             borrow_in,
	output logic      [WIDTH-1:0] diff_out,
	output logic                  borrow_out,
	output logic                  half_borrow_out,
	output logic                  overflow_out
);

	logic [WIDTH:0] full;
	logic [HALF:0]  low;

	always_comb begin
		full = {1'b0, minuend_in} - {1'b0, subtrahend_in} - {{WIDTH{1'b0}}, borrow_in};
		low  = {1'b0, minuend_in[HALF-1:0]} - {1'b0, subtrahend_in[HALF-1:0]}
			- {{HALF{1'b0}}, borrow_in};
		diff_out        = full[WIDTH-1:0];
		borrow_out      = full[WIDTH];
		half_borrow_out = low[HALF];
		overflow_out    = (minuend_in[WIDTH-1] != subtrahend_in[WIDTH-1])
			&& (full[WIDTH-1] != minuend_in[WIDTH-1]);
	end

endmodule // sub_unit

`default_nettype wire

// *** verification/exec_core_assertions.sv ***
// checker: port-level assertions for the execute core
`timescale 1ns/100ps
`default_nettype none

module exec_core_chk
	import exec_pkg::*;
#(
	parameter int DEPTH = FILE_DEPTH
) (
	input wire logic              clk_sys_in,
	input wire logic              resetn_in,
	input wire logic              psel_in,
	input wire logic              penable_in,
	input wire logic              pwrite_in,
	input wire logic [ADDR_W-1:0] paddr_in,
	input wire logic [31:0]       pwdata_in,
	input wire logic [31:0]       prdata_out,
	input wire logic              pready_out,
	input wire logic              pslverr_out,
	input wire logic              wake_in,
	input wire logic [DATA_W-1:0] io_port_out,
	input wire logic              sleep_out,
	input wire logic              clock_run_out
);
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!resetn_in);

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	logic stop_seen;
	logic wr_seen;
	always_ff @(posedge clk_sys_in or negedge resetn_in)
		if (!resetn_in) stop_seen <= 1'b0;
		else stop_seen <= psel_in && penable_in && pwrite_in && paddr_in == OFS_INSN
			&& pwdata_in[4:0] == op_stop;
	always_ff @(posedge clk_sys_in or negedge resetn_in)
		if (!resetn_in) wr_seen <= 1'b0;
		else wr_seen <= psel_in && penable_in && pwrite_in;

	sequence s_acc;
		psel_in && penable_in;
	endsequence
	sequence s_asleep2;
		sleep_out ##1 sleep_out;
	endsequence

	property p_ready; s_acc |-> pready_out; endproperty
	property p_err_phase; pslverr_out |-> psel_in && penable_in; endproperty
	property p_run_en; clock_run_out == !sleep_out; endproperty
	property p_sleep_cause; $rose(sleep_out) |-> stop_seen; endproperty
	property p_port_hold; s_asleep2 |-> $stable(io_port_out); endproperty
	property p_wake; sleep_out && wake_in |=> !sleep_out; endproperty
	property p_sleep_refuse;
		s_acc ##0 (sleep_out && pwrite_in && paddr_in != OFS_STATE) |-> pslverr_out;
	endproperty
	property p_cyc_ro; s_acc ##0 (pwrite_in && paddr_in == OFS_CYCLES) |-> pslverr_out; endproperty
	property p_port_cause; $changed(io_port_out) |-> wr_seen; endproperty

	a_ready: assert property (p_ready) else $error("pready low in access");
	a_err_phase: assert property (p_err_phase) else $error("stray error");
	a_run_en: assert property (p_run_en) else $error("clock enable wrong");
	a_sleep_cause: assert property (p_sleep_cause) else $error("sleep no stop");
	a_port_hold: assert property (p_port_hold) else $error("port moved asleep");
	a_wake: assert property (p_wake) else $error("no wake");
	a_sleep_refuse: assert property (p_sleep_refuse) else $error("write taken asleep");
	a_cyc_ro: assert property (p_cyc_ro) else $error("count writable");
	a_port_cause: assert property (p_port_cause) else $error("port moved alone");
endmodule // exec_core_chk

bind exec_core exec_core_chk #(.DEPTH(DEPTH)) u_exec_core_chk (
	.clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .psel_in(psel_in),
	.penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
	.pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
	.pslverr_out(pslverr_out), .wake_in(wake_in), .io_port_out(io_port_out),
	.sleep_out(sleep_out), .clock_run_out(clock_run_out));

`default_nettype wire

// *** verification/tb_exec_core.sv ***
// testbench: corner and random instruction runs over apb
`timescale 1ns/100ps
`default_nettype none

module tb_exec_core
	import exec_pkg::*;
;
	logic        clk_sys_in = 1'b0;
	logic        resetn_in = 1'b0;
	logic        psel, penable, pwrite, wake, pready, pslverr, sleep, clk_run, err;
	logic [7:0]  paddr, io_port;
	logic [31:0] pwdata, prdata, rdata, x, y;
	logic [31:0] seed = 32'h00003c5e;
	logic [5:0]  m_f;
	logic [15:0] m_n;
	logic [4:0]  o;
	int          errors, n_tests, cyc;

	exec_core #(.DEPTH(FILE_DEPTH)) u_exec_core (
		.clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .psel_in(psel),
		.penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
		.prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .wake_in(wake),
		.io_port_out(io_port), .sleep_out(sleep), .clock_run_out(clk_run));

	always #4 clk_sys_in = ~clk_sys_in;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task results();
		$display("tests %0d errors %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	always @(posedge clk_sys_in) begin
		cyc++;
		if (cyc == 30000) begin
			errors++;
			results();
		end
	end

	task chk(input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e) begin
			errors++;
			$display("[FAIL] %0t seen %h expected %h", $time, s, e);
		end
	endtask

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys_in);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys_in);
		penable <= 1'b1;
		@(posedge clk_sys_in);
		while (pready !== 1'b1) @(posedge clk_sys_in);
		rdata = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic run(input logic [4:0] op, input logic [3:0] i, input logic [2:0] b,
			input logic [7:0] imm, r, w, input logic [5:0] f);
		logic [7:0] a;
		logic [8:0] d;
		logic [4:0] h;
		logic       c;
		logic       sk;
		apb(1'b1, OFS_FILE + {2'b0, i, 2'b0}, {24'h0, r});
		apb(1'b1, OFS_WORK, {24'h0, w});
		apb(1'b1, OFS_FLAGS, {26'h0, f});
		apb(1'b1, OFS_INSN, {8'h0, imm, i, 1'b0, b, 3'h0, op});
		m_f = f;
		sk = 1'b0;
		a = (op == op_subtract_from_immediate) ? imm : r;
		c = f[FLAG_BORROW] && (op inside {op_subtract_with_borrow_to_work,
			op_subtract_with_borrow_to_reg});
		d = {1'b0, a} - {1'b0, w} - {8'h0, c};
		h = {1'b0, a[3:0]} - {1'b0, w[3:0]} - {4'h0, c};
		case (op)
		op_set_all: r = ALL_ONES;
		op_bit_force_high: r[b] = 1'b1;
		op_subtract_from_immediate, op_subtract_into_work, op_subtract_into_reg,
		op_subtract_with_borrow_to_work, op_subtract_with_borrow_to_reg: begin
			m_f[3:0] = {a[7] != w[7] && d[7] != a[7], d[7:0] == 8'h00, h[4], d[8]};
			if (op inside {op_subtract_into_reg, op_subtract_with_borrow_to_reg}) r = d[7:0];
			else w = d[7:0];
		end
		op_nibble_exchange_to_work: w = {r[3:0], r[7:4]};
		op_nibble_exchange_to_reg: r = {r[3:0], r[7:4]};
		op_skip_if_bit_clear: sk = !r[b];
		op_skip_if_bit_set: sk = r[b];
		op_load_work_skip_if_zero: w = r;
		op_increment_to_work_skip_if_zero: w = r + ONE;
		op_increment_in_place_skip_if_zero: r = r + ONE;
		op_decrement_to_work_skip_if_zero: w = r - ONE;
		op_decrement_in_place_skip_if_zero: r = r - ONE;
		op_exclusive_or_immediate: w = w ^ imm;
		op_exclusive_or_into_work: w = w ^ r;
		op_exclusive_or_into_reg: r = r ^ w;
		default: ;
		endcase
		if (op inside {op_load_work_skip_if_zero, op_increment_to_work_skip_if_zero,
			op_decrement_to_work_skip_if_zero}) sk = w == 8'h00;
		if (op inside {op_retest_reg_skip_if_zero, op_increment_in_place_skip_if_zero,
			op_decrement_in_place_skip_if_zero}) sk = r == 8'h00;
		if (op inside {op_exclusive_or_immediate, op_exclusive_or_into_work})
			m_f[FLAG_NIL] = w == 8'h00;
		if (op inside {op_exclusive_or_into_reg, op_reg_zero_probe})
			m_f[FLAG_NIL] = r == 8'h00;
		m_n = m_n + (sk ? 16'h2 : 16'h1);
		apb(1'b0, OFS_INSN, 32'h0);
		chk(rdata, {8'h0, imm, i, 1'b0, b, 3'h0, op});
		apb(1'b0, OFS_WORK, 32'h0);
		chk(rdata, {24'h0, w});
		apb(1'b0, OFS_FLAGS, 32'h0);
		chk(rdata, {26'h0, m_f});
		apb(1'b0, OFS_FILE + {2'b0, i, 2'b0}, 32'h0);
		chk(rdata, {24'h0, r});
		apb(1'b0, OFS_STATE, 32'h0);
		chk(rdata[1:0], {1'b0, sk});
		if (sk) begin
			apb(1'b1, OFS_INSN, {16'h00ff, 11'h0, op_exclusive_or_immediate});
			apb(1'b0, OFS_WORK, 32'h0);
			chk(rdata, {24'h0, w});
			apb(1'b0, OFS_STATE, 32'h0);
			chk(rdata[1:0], 2'b00);
		end
		$display("test op %h done", op);
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		{psel, penable, pwrite, wake} = 4'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		{errors, n_tests, cyc} = '0;
		m_n = 16'h0;
		repeat (4) @(posedge clk_sys_in);
		resetn_in <= 1'b1;
		apb(1'b0, OFS_FLAGS, 32'h0);
		chk(rdata, 32'h0);
		run(op_subtract_from_immediate, 4'h1, 3'h0, 8'h80, 8'h00, 8'h77, 6'h00);
		run(op_subtract_into_reg, 4'h1, 3'h0, 8'h00, 8'h80, 8'h77, 6'h00);
		run(op_subtract_with_borrow_to_work, 4'h1, 3'h0, 8'h00, 8'h80, 8'h77, 6'h01);
		run(op_subtract_with_borrow_to_reg, 4'h2, 3'h0, 8'h00, 8'h7f, 8'hff, 6'h01);
		run(op_nibble_exchange_to_reg, 4'h3, 3'h0, 8'h00, 8'h35, 8'h00, 6'h3f);
		run(op_bit_force_high, 4'h0, 3'h7, 8'h00, 8'h00, 8'h00, 6'h00);
		run(op_increment_to_work_skip_if_zero, 4'h4, 3'h0, 8'h00, 8'hff, 8'h01, 6'h00);
		run(op_decrement_in_place_skip_if_zero, 4'h5, 3'h0, 8'h00, 8'h01, 8'h00, 6'h00);
		run(op_skip_if_bit_clear, 4'h6, 3'h3, 8'h00, 8'h08, 8'h00, 6'h00);
		run(op_skip_if_bit_set, 4'h6, 3'h3, 8'h00, 8'h08, 8'h00, 6'h00);
		run(op_load_work_skip_if_zero, 4'hf, 3'h0, 8'h00, 8'h00, 8'h05, 6'h00);
		run(op_exclusive_or_immediate, 4'h0, 3'h0, 8'h0a, 8'h00, 8'h0a, 6'h00);
		repeat (60) begin
			x = xs();
			y = xs();
			o = 5'(1 + x % 22);
			if (o == op_stop) o = op_nop;
			run(o, x[11:8], x[14:12], x[23:16], y[7:0], y[15:8], y[21:16]);
		end
		apb(1'b1, OFS_FILE, 32'h5a);
		apb(1'b1, OFS_INSN, {27'h0, op_stop});
		apb(1'b0, OFS_FLAGS, 32'h0);
		chk(rdata[5:4], 2'b10);
		chk({sleep, clk_run}, 2'b10);
		apb(1'b1, OFS_FILE, 32'ha5);
		chk(err, 1'b1);
		apb(1'b1, OFS_INSN, {27'h0, op_set_all});
		chk({err, io_port}, 9'h15a);
		wake <= 1'b1;
		@(posedge clk_sys_in);
		wake <= 1'b0;
		apb(1'b0, OFS_STATE, 32'h0);
		chk(rdata[1:0], 2'b00);
		apb(1'b1, OFS_INSN, {27'h0, op_stop});
		apb(1'b1, OFS_STATE, 32'h1);
		apb(1'b0, OFS_STATE, 32'h0);
		chk({rdata[1:0], sleep}, 3'h0);
		apb(1'b1, OFS_CYCLES, 32'h0);
		chk(err, 1'b1);
		apb(1'b0, 8'h30, 32'h0);
		chk(err, 1'b1);
		apb(1'b0, OFS_CYCLES, 32'h0);
		chk(rdata[15:0], m_n + 16'h2);
		results();
	end
endmodule // tb_exec_core

`default_nettype wire
